// ===== shared/aws_pkg.sv
// package: register map, field layout, reset values and timing for auto wake/sleep control
package aws_pkg;

  // ********************
  // register map
  // ********************
  localparam logic [7:0] ADDR_X_MSB = 8'h01;
  localparam logic [7:0] ADDR_Y_MSB = 8'h03;
  localparam logic [7:0] ADDR_Z_MSB = 8'h05;
  localparam logic [7:0] ADDR_INACTIVITY_DURATION = 8'h29;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE = 8'h2A;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_TWO = 8'h2B;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h2C;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'h2D;

  // ********************
  // fields and reset values
  // ********************
  localparam int SLEEP_RATE_HI = 7;
  localparam int SLEEP_RATE_LO = 6;
  localparam int WAKE_RATE_HI = 5;
  localparam int WAKE_RATE_LO = 3;
  localparam int FAST_READ_BIT = 1;
  localparam int ACTIVE_BIT = 0;
  localparam int AUTO_SLEEP_ENABLE_BIT = 2;
  localparam int ORIENTATION_WAKE_BIT = 5;
  localparam int MOTION_WAKE_BIT = 3;
  localparam int SLEEP_INT_ENABLE_BIT = 7;
  localparam int ORIENTATION_INT_ENABLE_BIT = 4;
  localparam int MOTION_INT_ENABLE_BIT = 2;
  localparam logic [7:0] CONTROL_ONE_MASK = 8'hFB;
  localparam logic [7:0] INACTIVITY_DURATION_RESET = 8'h00;
  localparam logic [7:0] SYSTEM_CONTROL_ONE_RESET = 8'h00;

  // ********************
  // timing
  // ********************
  localparam int CLK_PERIOD_NS = 40;
  localparam int FASTEST_PERIOD_NS = 1250000;
  localparam int FASTEST_PERIOD_CYCLES = FASTEST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DURATION_STEP_MS = 320;
  localparam int DURATION_LONG_STEP_MS = 640;
  localparam int FASTEST_PERIOD_US = FASTEST_PERIOD_NS / 1000;
  // rates are held as log2 of the period in fastest-rate periods
  localparam logic [3:0] STEP_LOG = 4'(DURATION_STEP_MS * 1000 / FASTEST_PERIOD_US == 256 ? 8 : 8);
  localparam logic [3:0] SLOWEST_LOG = 4'h9;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_WAKE = 2'b01,
    MODE_SLEEP = 2'b10
  } mode_t;

  function automatic logic [3:0] wake_log(input logic [2:0] code);
    unique case (code)
      3'h0: wake_log = 4'h0;
      3'h1: wake_log = 4'h1;
      3'h2: wake_log = 4'h2;
      3'h3: wake_log = 4'h3;
      3'h4: wake_log = 4'h4;
      3'h5: wake_log = 4'h6;
      3'h6: wake_log = 4'h7;
      3'h7: wake_log = SLOWEST_LOG;
    endcase
  endfunction : wake_log

  function automatic logic [3:0] sleep_log(input logic [1:0] code);
    unique case (code)
      2'h0: sleep_log = 4'h4;
      2'h1: sleep_log = 4'h6;
      2'h2: sleep_log = 4'h7;
      2'h3: sleep_log = SLOWEST_LOG;
    endcase
  endfunction : sleep_log

  // sample ticks per duration count: 320 ms, or one 640 ms tick at the slowest rate
  function automatic logic [8:0] ticks_per_count(input logic [3:0] rate_log);
    if (rate_log >= STEP_LOG) begin
      ticks_per_count = 9'h001;
    end else begin
      ticks_per_count = 9'(9'h001 << (STEP_LOG - rate_log));
    end
  endfunction : ticks_per_count

endpackage : aws_pkg

// ===== shared/rate_tick_if.sv
// interface: selected sample rate out, sample tick back
`timescale 1ns/1ns
interface rate_tick_if;
  logic [3:0] rate_log;
  logic tick;
  modport ctrl (output rate_log, input tick);
  modport gen (input rate_log, output tick);
endinterface : rate_tick_if

// ===== verilog/sample_tick_gen.sv
// sample-rate tick generator
`timescale 1ns/1ns
module sample_tick_gen #(
  parameter int FASTEST_CYCLES = aws_pkg::FASTEST_PERIOD_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  rate_tick_if.gen rt
);
  import aws_pkg::*;

  typedef struct packed {
    logic [23:0] count;
    logic [3:0] last_log;
    logic tick;
  } gen_state_t;

  gen_state_t st;
  gen_state_t next_st;
  logic [23:0] period;

  always_comb begin
    period = 24'(24'(FASTEST_CYCLES) << rt.rate_log);
    next_st = st;
    next_st.tick = 1'b0;
    next_st.last_log = rt.rate_log;
    // a rate change restarts the period so no short tick slips out
    if (rt.rate_log != st.last_log || st.count >= period - 24'h000001) begin
      next_st.count = 24'h000000;
      next_st.tick = (rt.rate_log == st.last_log);
    end else begin
      next_st.count = st.count + 24'h000001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rt.tick = st.tick;

  tick_single_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st.tick |=> !st.tick) else $error("sample tick longer than one cycle");

endmodule : sample_tick_gen

// ===== verilog/auto_wake_sleep_rate_control.sv
// top: auto wake/sleep timer, rate selection and system control registers
`timescale 1ns/1ns
// Overview of operation
// - after programmed inactivity with auto-sleep on, drop from wake rate to sleep rate
// - auto switching only while auto-sleep enabled; wake and sleep rates from their fields
// - one duration count is 320 ms, or 640 ms at 1.56 Hz wake rate
// - only orientation and motion events restart the timer; those events or clearing auto-sleep wake the device
// - while asleep, detection functions run on the sleep-rate tick
// - enabled but unselected functions never wake the device
// - with auto-sleep off, only standby and wake are reachable
// - with its interrupt enabled, each wake/sleep change raises an event
// - control one: sleep rate 7-6, wake rate 5-3, bit 2 zero, fast-read, active
// - sleep codes pick 50, 12.5, 6.25, 1.56 Hz and override every block
// - wake codes pick 800 down to 1.56 Hz; 800 Hz after reset
// - active bit: 0 standby (reset), 1 active
// - fast-read makes output-register auto-increment skip the X and Y low data bytes
// - auto-sleep enable is control two bit 2, reset 0
// - orientation wake select lets orientation wake the device when set
module auto_wake_sleep_rate_control #(
  parameter int FASTEST_CYCLES = aws_pkg::FASTEST_PERIOD_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic orientation_event_in,
  input wire logic motion_event_in,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] next_addr_out,
  output logic sample_tick_out,
  output logic [3:0] sample_rate_log_out,
  output logic active_out,
  output logic sleep_state_out,
  output logic fast_read_out,
  output logic sleep_transition_out
);
  import aws_pkg::*;

  typedef struct packed {
    logic [7:0] inactivity_duration;
    logic [7:0] system_control_one;
    logic auto_sleep_enable;
    logic orientation_wake_select;
    logic motion_wake_select;
    logic sleep_int_enable;
    logic orientation_int_enable;
    logic motion_int_enable;
    mode_t mode;
    logic [7:0] step_cnt;
    logic [8:0] sub_cnt;
    logic transition;
    logic [3:0] rate_log;
    logic tick;
    logic [7:0] rdata;
    logic [7:0] next_addr;
    logic active;
    logic asleep;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;
  rate_tick_if rt ();

  logic [2:0] wake_rate_select;
  logic [1:0] sleep_rate_select;
  logic fast_read;
  logic active_req;
  logic restart_evt;
  logic wake_evt;
  logic expired;
  logic [8:0] tpc;

  sample_tick_gen #(
    .FASTEST_CYCLES(FASTEST_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .rt(rt)
  );

  // ********************
  // decode
  // ********************
  assign wake_rate_select = st.system_control_one[WAKE_RATE_HI:WAKE_RATE_LO];
  assign sleep_rate_select = st.system_control_one[SLEEP_RATE_HI:SLEEP_RATE_LO];
  assign fast_read = st.system_control_one[FAST_READ_BIT];
  assign active_req = st.system_control_one[ACTIVE_BIT];
  // sleep rate overrides everything while asleep
  assign rt.rate_log = (st.mode == MODE_SLEEP) ? sleep_log(sleep_rate_select)
                                               : wake_log(wake_rate_select);
  // only enabled orientation or motion functions count; data-ready never does
  assign restart_evt = (orientation_event_in && st.orientation_int_enable) ||
                       (motion_event_in && st.motion_int_enable);
  // an event wakes only when also selected for wake
  assign wake_evt = (orientation_event_in && st.orientation_int_enable &&
                     st.orientation_wake_select) ||
                    (motion_event_in && st.motion_int_enable && st.motion_wake_select);
  assign tpc = ticks_per_count(wake_log(wake_rate_select));
  assign expired = st.step_cnt >= st.inactivity_duration;

  // ********************
  // next state
  // ********************
  always_comb begin
    next_st = st;
    next_st.transition = 1'b0;
    next_st.rate_log = rt.rate_log;
    next_st.tick = rt.tick;
    // register writes; bit 2 of control one always reads zero
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_INACTIVITY_DURATION: next_st.inactivity_duration = reg_wdata_in;
        ADDR_SYSTEM_CONTROL_ONE:
          next_st.system_control_one = reg_wdata_in & CONTROL_ONE_MASK;
        ADDR_SYSTEM_CONTROL_TWO:
          next_st.auto_sleep_enable = reg_wdata_in[AUTO_SLEEP_ENABLE_BIT];
        ADDR_INTERRUPT_CONTROL: begin
          next_st.orientation_wake_select = reg_wdata_in[ORIENTATION_WAKE_BIT];
          next_st.motion_wake_select = reg_wdata_in[MOTION_WAKE_BIT];
        end
        ADDR_INTERRUPT_ENABLE: begin
          next_st.sleep_int_enable = reg_wdata_in[SLEEP_INT_ENABLE_BIT];
          next_st.orientation_int_enable = reg_wdata_in[ORIENTATION_INT_ENABLE_BIT];
          next_st.motion_int_enable = reg_wdata_in[MOTION_INT_ENABLE_BIT];
        end
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_INACTIVITY_DURATION: next_st.rdata = st.inactivity_duration;
        ADDR_SYSTEM_CONTROL_ONE: next_st.rdata = st.system_control_one;
        ADDR_SYSTEM_CONTROL_TWO:
          next_st.rdata = 8'(st.auto_sleep_enable) << AUTO_SLEEP_ENABLE_BIT;
        ADDR_INTERRUPT_CONTROL:
          next_st.rdata = (8'(st.orientation_wake_select) << ORIENTATION_WAKE_BIT) |
                          (8'(st.motion_wake_select) << MOTION_WAKE_BIT);
        ADDR_INTERRUPT_ENABLE:
          next_st.rdata = (8'(st.sleep_int_enable) << SLEEP_INT_ENABLE_BIT) |
                          (8'(st.orientation_int_enable) << ORIENTATION_INT_ENABLE_BIT) |
                          (8'(st.motion_int_enable) << MOTION_INT_ENABLE_BIT);
        default: next_st.rdata = 8'h00;
      endcase
      // fast-read hops from the X and Y high bytes to the next high byte
      if (fast_read && (reg_addr_in == ADDR_X_MSB || reg_addr_in == ADDR_Y_MSB)) begin
        next_st.next_addr = reg_addr_in + 8'h02;
      end else begin
        next_st.next_addr = reg_addr_in + 8'h01;
      end
    end
    // ********************
    // wake/sleep sequencing
    // ********************
    unique case (st.mode)
      MODE_STANDBY: begin
        if (active_req) begin
          next_st.mode = MODE_WAKE;
          next_st.step_cnt = 8'h00;
          next_st.sub_cnt = 9'h000;
        end
      end
      MODE_WAKE: begin
        if (!active_req) begin
          next_st.mode = MODE_STANDBY;
        end else if (restart_evt) begin
          next_st.step_cnt = 8'h00;
          next_st.sub_cnt = 9'h000;
        end else if (st.auto_sleep_enable && expired) begin
          next_st.mode = MODE_SLEEP;
          next_st.transition = st.sleep_int_enable;
        end else if (rt.tick) begin
          // step counter saturates so a long quiet spell cannot wrap
          if (st.sub_cnt >= tpc - 9'h001) begin
            next_st.sub_cnt = 9'h000;
            if (st.step_cnt != 8'hFF) begin
              next_st.step_cnt = st.step_cnt + 8'h01;
            end
          end else begin
            next_st.sub_cnt = st.sub_cnt + 9'h001;
          end
        end
      end
      MODE_SLEEP: begin
        if (!active_req) begin
          next_st.mode = MODE_STANDBY;
        end else if (wake_evt || !st.auto_sleep_enable) begin
          next_st.mode = MODE_WAKE;
          next_st.transition = st.sleep_int_enable;
          next_st.step_cnt = 8'h00;
          next_st.sub_cnt = 9'h000;
        end
      end
      default: next_st.mode = MODE_STANDBY;
    endcase
    // mode flags kept in flops so the status outputs carry no decode glitches
    next_st.active = (next_st.mode != MODE_STANDBY);
    next_st.asleep = (next_st.mode == MODE_SLEEP);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.inactivity_duration <= INACTIVITY_DURATION_RESET;
      st.system_control_one <= SYSTEM_CONTROL_ONE_RESET;
      st.mode <= MODE_STANDBY;
    end else begin
      st <= next_st;
    end
  end

  // ********************
  // outputs
  // ********************
  assign reg_rdata_out = st.rdata;
  assign next_addr_out = st.next_addr;
  assign sample_tick_out = st.tick;
  assign sample_rate_log_out = st.rate_log;
  assign active_out = st.active;
  assign sleep_state_out = st.asleep;
  assign fast_read_out = fast_read;
  assign sleep_transition_out = st.transition;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sleep_entry_a: assert property (st.mode == MODE_WAKE && active_req && !restart_evt &&
    st.auto_sleep_enable && expired |=> st.mode == MODE_SLEEP) else $error("no sleep entry");
  wake_rate_a: assert property (st.mode == MODE_WAKE |=> st.rate_log ==
    wake_log($past(wake_rate_select))) else $error("wrong wake rate");
  sleep_rate_a: assert property (st.mode == MODE_SLEEP |=> st.rate_log ==
    sleep_log($past(sleep_rate_select))) else $error("wrong sleep rate");
  timer_restart_a: assert property (st.mode == MODE_WAKE && active_req && restart_evt
    |=> st.mode == MODE_WAKE && st.step_cnt == 8'h00) else $error("timer not restarted");
  no_stray_wake_a: assert property (st.mode == MODE_SLEEP && active_req &&
    st.auto_sleep_enable && !wake_evt |=> st.mode == MODE_SLEEP) else $error("stray wake");
  sleep_needs_enable_a: assert property (st.mode == MODE_SLEEP |->
    $past(st.auto_sleep_enable)) else $error("sleep without enable");
  transition_event_a: assert property (st.mode != $past(st.mode) &&
    st.mode != MODE_STANDBY && $past(st.mode) != MODE_STANDBY && $past(st.sleep_int_enable)
    |-> sleep_transition_out) else $error("missing transition event");
  orientation_wake_a: assert property (st.mode == MODE_SLEEP && active_req &&
    orientation_event_in && st.orientation_int_enable && st.orientation_wake_select
    |=> st.mode == MODE_WAKE && st.step_cnt == 8'h00) else $error("orientation did not wake");
  standby_a: assert property (!active_req |=> st.mode == MODE_STANDBY)
    else $error("not standby");
  fast_skip_a: assert property (reg_rd_in && fast_read && reg_addr_in == ADDR_X_MSB
    |=> next_addr_out == ADDR_Y_MSB) else $error("fast-read did not skip");

  sleep_seen_c: cover property (st.mode == MODE_WAKE ##1 st.mode == MODE_SLEEP);
  woke_c: cover property (st.mode == MODE_SLEEP ##1 st.mode == MODE_WAKE);
  restart_c: cover property (st.mode == MODE_WAKE && restart_evt && st.step_cnt != 8'h00);

endmodule : auto_wake_sleep_rate_control

// ===== tb/host_model.sv
// host model: register-port master standing where the host processor sits
`timescale 1ns/1ns
module host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic [7:0] next_addr_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  logic [7:0] shadow_one = 8'h00;
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // released lines show the inverse so stale values never look valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    addr_out <= addr;
    wdata_out <= data;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~addr;
    wdata_out <= ~data;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic [7:0] nxt);
    @(posedge clk_in);
    addr_out <= addr;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~addr;
    #1;
    data = rdata_in;
    nxt = next_addr_in;
  endtask : read_reg
  // drop to standby before touching fields, then restore active
  task automatic write_ctrl_one(input logic [7:0] v);
    if (shadow_one[0]) begin
      write_reg(8'h2A, shadow_one & 8'hFE);
    end
    write_reg(8'h2A, v & 8'hFE);
    if (v[0]) begin
      write_reg(8'h2A, v);
    end
    shadow_one = v;
  endtask : write_ctrl_one
endmodule : host_model

// ===== tb/auto_wake_sleep_rate_control_bench.sv
// testbench: register map, rate selection, auto wake/sleep timing and wake sources
`timescale 1ns/1ns
module auto_wake_sleep_rate_control_bench;
  import aws_pkg::*;
  localparam int FC = 4;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic orientation_event_in = 1'b0;
  logic motion_event_in = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_out, next_addr_out;
  logic reg_wr, reg_rd, sample_tick_out, active_out, sleep_state_out;
  logic fast_read_out, sleep_transition_out;
  logic [3:0] sample_rate_log_out;
  logic [7:0] lfsr = 8'h5F;
  logic [7:0] d, na;
  logic [1:0] sc;
  int error_cnt = 0;
  int n_checks = 0;
  int ticks, cyc, gap;

  always #20 clk_in = ~clk_in;

  host_model host (.clk_in(clk_in), .rdata_in(reg_rdata_out), .next_addr_in(next_addr_out),
    .addr_out(reg_addr), .wr_out(reg_wr), .rd_out(reg_rd), .wdata_out(reg_wdata));

  auto_wake_sleep_rate_control #(.FASTEST_CYCLES(FC)) dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_wdata_in(reg_wdata), .orientation_event_in(orientation_event_in),
    .motion_event_in(motion_event_in), .reg_rdata_out(reg_rdata_out),
    .next_addr_out(next_addr_out), .sample_tick_out(sample_tick_out),
    .sample_rate_log_out(sample_rate_log_out), .active_out(active_out),
    .sleep_state_out(sleep_state_out), .fast_read_out(fast_read_out),
    .sleep_transition_out(sleep_transition_out));

  // ********************
  // helpers
  // ********************
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  // rates as log2 of period in 1.25 ms steps
  function automatic logic [3:0] exp_wake_log(input logic [2:0] c);
    return c < 3'h5 ? {1'b0, c} : (c == 3'h5 ? 4'h6 : (c == 3'h6 ? 4'h7 : 4'h9));
  endfunction : exp_wake_log
  function automatic logic [3:0] exp_sleep_log(input logic [1:0] c);
    return c == 2'h0 ? 4'h4 : (c == 2'h1 ? 4'h6 : (c == 2'h2 ? 4'h7 : 4'h9));
  endfunction : exp_sleep_log
  task automatic check_val(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check_val
  task automatic check_flag(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : check_flag
  task automatic wait_state(input logic want, input int limit);
    ticks = 0;
    cyc = 0;
    while (sleep_state_out !== want && cyc < limit) begin
      @(posedge clk_in);
      #1;
      cyc++;
      if (sample_tick_out === 1'b1) ticks++;
    end
  endtask : wait_state
  task automatic tick_gap();
    int n;
    n = 0;
    while (sample_tick_out !== 1'b1 && n < 5000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    gap = 0;
    do begin
      @(posedge clk_in);
      #1;
      gap++;
    end while (sample_tick_out !== 1'b1 && gap < 5000);
  endtask : tick_gap
  task automatic pulse(input logic orient);
    @(posedge clk_in);
    if (orient) orientation_event_in <= 1'b1;
    else motion_event_in <= 1'b1;
    @(posedge clk_in);
    orientation_event_in <= 1'b0;
    motion_event_in <= 1'b0;
  endtask : pulse
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // a full run needs about 14k cycles; slowest-rate waits dominate
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    give_verdict();
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check_flag("active after reset", 1'b0, active_out);
    host.read_reg(ADDR_INACTIVITY_DURATION, d, na);
    check_val("duration reset", 8'h00, d);
    host.read_reg(ADDR_SYSTEM_CONTROL_ONE, d, na);
    check_val("control one reset", 8'h00, d);
    host.read_reg(ADDR_SYSTEM_CONTROL_TWO, d, na);
    check_val("control two reset", 8'h00, d);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      host.write_reg(ADDR_INACTIVITY_DURATION, lfsr);
      host.read_reg(ADDR_INACTIVITY_DURATION, d, na);
      check_val("duration", lfsr, d);
      lfsr = lfsr_next(lfsr);
      host.write_ctrl_one(lfsr & 8'hFE);
      host.read_reg(ADDR_SYSTEM_CONTROL_ONE, d, na);
      check_val("control one", lfsr & 8'hFA, d);
    end
    host.read_reg(8'h40, d, na);
    check_val("unmapped", 8'h00, d);
    // every wake code, with the tick spacing it implies
    for (int i = 0; i < 8; i++) begin
      host.write_ctrl_one({2'b00, 3'(i), 3'b001});
      repeat (2) @(posedge clk_in);
      #1;
      check_flag("active", 1'b1, active_out);
      check_val("wake rate", {4'h0, exp_wake_log(3'(i))}, {4'h0, sample_rate_log_out});
      tick_gap();
      check_flag("wake tick gap", 1'b1, gap == (FC << exp_wake_log(3'(i))));
    end
    host.write_ctrl_one(8'h02);
    #1;
    check_flag("fast read", 1'b1, fast_read_out);
    host.read_reg(ADDR_X_MSB, d, na);
    check_val("fast next addr", ADDR_Y_MSB, na);
    host.write_ctrl_one(8'h00);
    host.read_reg(ADDR_X_MSB, d, na);
    check_val("plain next addr", 8'h02, na);
    // auto-sleep with motion keeping the device awake
    sc = lfsr[1:0];
    host.write_reg(ADDR_INTERRUPT_ENABLE, 8'h84);
    host.read_reg(ADDR_INTERRUPT_ENABLE, d, na);
    check_val("interrupt enable", 8'h84, d);
    host.write_reg(ADDR_SYSTEM_CONTROL_TWO, 8'h04);
    host.read_reg(ADDR_SYSTEM_CONTROL_TWO, d, na);
    check_val("control two", 8'h04, d);
    host.write_reg(ADDR_INACTIVITY_DURATION, 8'h01);
    host.write_ctrl_one({sc, 3'b000, 3'b001});
    for (int i = 0; i < 3; i++) begin
      repeat (800) @(posedge clk_in);
      pulse(1'b0);
    end
    #1;
    check_flag("held awake", 1'b0, sleep_state_out);
    wait_state(1'b1, 1200);
    check_flag("asleep", 1'b1, sleep_state_out);
    check_flag("tick count", 1'b1, ticks >= 255 && ticks <= 257);
    check_flag("sleep pulse", 1'b1, sleep_transition_out);
    repeat (2) @(posedge clk_in);
    #1;
    check_val("sleep rate", {4'h0, exp_sleep_log(sc)}, {4'h0, sample_rate_log_out});
    tick_gap();
    check_flag("sleep tick gap", 1'b1, gap == (FC << exp_sleep_log(sc)));
    host.write_reg(ADDR_INTERRUPT_CONTROL, 8'h00);
    pulse(1'b0);
    repeat (10) @(posedge clk_in);
    #1;
    check_flag("unselected wake", 1'b1, sleep_state_out);
    host.write_reg(ADDR_INTERRUPT_ENABLE, 8'h94);
    host.write_reg(ADDR_INTERRUPT_CONTROL, 8'h20);
    host.read_reg(ADDR_INTERRUPT_CONTROL, d, na);
    check_val("wake select", 8'h20, d);
    pulse(1'b1);
    #1;
    check_flag("orientation wake", 1'b0, sleep_state_out);
    check_flag("wake pulse", 1'b1, sleep_transition_out);
    // auto-sleep off with zero duration never sleeps
    host.write_reg(ADDR_SYSTEM_CONTROL_TWO, 8'h00);
    host.write_reg(ADDR_INACTIVITY_DURATION, 8'h00);
    wait_state(1'b1, 50);
    check_flag("no auto sleep", 1'b0, sleep_state_out);
    host.write_reg(ADDR_SYSTEM_CONTROL_TWO, 8'h04);
    wait_state(1'b1, 10);
    check_flag("zero duration", 1'b1, sleep_state_out);
    // motion selected for wake brings it out for one cycle before zero duration expires
    host.write_reg(ADDR_INTERRUPT_CONTROL, 8'h08);
    pulse(1'b0);
    #1;
    check_flag("motion wake", 1'b0, sleep_state_out);
    check_flag("motion wake pulse", 1'b1, sleep_transition_out);
    // slowest wake rate uses one tick per count
    host.write_reg(ADDR_INACTIVITY_DURATION, 8'h02);
    host.write_ctrl_one({2'b00, 3'b111, 3'b001});
    wait_state(1'b1, 8000);
    check_flag("slow asleep", 1'b1, sleep_state_out);
    check_flag("slow ticks", 1'b1, ticks >= 1 && ticks <= 3 && cyc > 2048);
    give_verdict();
  end
endmodule : auto_wake_sleep_rate_control_bench
